// ### verilog/adc_port_pkg.sv
/*
  Shared constants and types for the converter serial port.
  Assumes a 50 MHz system clock and a host-driven serial clock.
*/
package adc_port_pkg;

  // ==========================================================
  // Frame format
  localparam int WORD_W = 24;
  localparam int CMD_W = 8;
  localparam int REG_SEL_LSB = 3;
  localparam int REG_SEL_W = 3;
  localparam int NUM_REGS = 8;
  localparam logic [2:0] DATA_REG_SEL = 3'h3;
  localparam logic [4:0] LAST_CMD_BIT = 5'h07;
  localparam logic [4:0] LAST_WORD_BIT = 5'h17;
  localparam logic CMD_READ_BIT = 1'h1;
  localparam int CMD_RW_POS = 6;

  // ==========================================================
  // Timing
  localparam int MCLK_HZ = 50_000_000;
  localparam int INT_CLK_HZ = 4_920_000;
  // Divider half period: longest time rounds down, at least one cycle
  localparam int INT_CLK_HALF_RAW = MCLK_HZ / (2 * INT_CLK_HZ);
  localparam int INT_CLK_HALF = (INT_CLK_HALF_RAW < 1) ? 1 : INT_CLK_HALF_RAW;
  localparam logic [7:0] INT_CLK_HALF_CNT = 8'(INT_CLK_HALF);
  localparam logic [23:0] CONV_PERIOD_DEF = 24'h00_2710;
  localparam logic [23:0] READY_LEAD = 24'h00_0010;
  localparam logic [23:0] RESET_VALUE_WORD = 24'h00_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [2:0] sel;
    logic [WORD_W-1:0] data;
  } reg_write_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } result_t;

endpackage

// ### verilog/word_buffer2.sv
/*
  Two-entry valid/ready buffer for register write words.
  Assumes one clock domain; both sides handshake on mclk.
*/
`timescale 1ns/1ps
module word_buffer2 (
  input wire logic mclk,
  input wire logic resetn,
  input wire adc_port_pkg::reg_write_t in_word,
  input wire logic in_valid,
  output logic in_ready,
  output adc_port_pkg::reg_write_t out_word,
  output logic out_valid,
  input wire logic out_ready
);
  import adc_port_pkg::*;

  reg_write_t mem_r [2];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_word = mem_r[rptr_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wptr_r] <= in_word;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end
endmodule

// ### verilog/adc_serial_port.sv
/*
  Serial host port of a sigma-delta converter with ready signalling,
  filter synchronisation and master clock output.
  Assumes the host drives sclk as a clock into the link domain; select
  and sync pins are sampled through two flip-flops before use on mclk.
*/
// What this block does
// - Sync low resets filter and conversion counter, holds modulator.
// - Sync leaves serial interface and transfers in progress untouched.
// - Sync low forces a pending ready indication back high.
// - Data-out line falls low when a conversion completes.
// - Unread result: ready returns high before next result update.
// - Output bits change on sclk fall, host samples on rise.
// - Output shifter loads from any data or control register.
// - Input bits go to the control register chosen by command select bits.
// - Select also works as frame delimiter for each transfer.
// - Select tied low still works, three-wire operation.
// - Continuous or gapped serial clock both accepted.
// - Internal master clock made, optionally driven on master clock pin.
`timescale 1ns/1ps
module adc_serial_port (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout_rdy_o,
  output logic dout_rdy_oe,
  input wire logic sync_n,
  input wire logic clk_out_en,
  input wire logic ext_clk_sel,
  input wire logic crystal_in_pin,
  output logic master_clock_pin_o,
  output logic master_clock_pin_oe,
  input wire logic [23:0] sample_in,
  output logic modulator_reset,
  output logic filter_reset
);
  import adc_port_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_DATA} link_state_t;

  function automatic logic [2:0] cmd_sel(input logic [CMD_W-1:0] c);
    cmd_sel = c[REG_SEL_LSB +: REG_SEL_W];
  endfunction

  // ==========================================================
  // Link domain: sclk, reset by select high or system reset
  logic cs_link_s1_r;
  logic cs_link_s2_r;
  logic rst_link_s1_r;
  logic rst_link_s2_r;
  link_state_t lstate_r;
  logic [4:0] bit_cnt_r;
  logic [CMD_W-1:0] cmd_r;
  logic [WORD_W-1:0] in_sh_r;
  logic [WORD_W-1:0] out_sh_r;
  logic out_bit_r;
  logic in_data_r;
  logic wr_tgl_r;
  logic rd_tgl_r;
  logic [2:0] wr_sel_r;
  logic [WORD_W-1:0] wr_data_r;
  logic [WORD_W-1:0] snap_s1_r [NUM_REGS];
  logic [WORD_W-1:0] snap_r [NUM_REGS];
  logic [WORD_W-1:0] regs_r [NUM_REGS];
  logic link_rst;

  always_ff @(posedge sclk) begin
    rst_link_s1_r <= resetn;
    rst_link_s2_r <= rst_link_s1_r;
    cs_link_s1_r <= cs_n;
    cs_link_s2_r <= cs_link_s1_r;
  end

  // Select high frames the transfer; tied low never resets it
  assign link_rst = !rst_link_s2_r || cs_link_s2_r;

  // Register contents carried into the sclk domain; words change rarely
  always_ff @(posedge sclk) begin
    snap_s1_r <= regs_r;
    snap_r <= snap_s1_r;
  end

  // Input shifting on rising sclk, command then data word
  always_ff @(posedge sclk) begin
    if (link_rst) begin
      lstate_r <= ST_CMD;
      bit_cnt_r <= 5'h00;
      cmd_r <= '0;
      in_sh_r <= '0;
      in_data_r <= 1'b0;
      // Toggles survive select high, else a false write would cross
      if (!rst_link_s2_r) begin
        wr_tgl_r <= 1'b0;
        rd_tgl_r <= 1'b0;
        wr_sel_r <= '0;
        wr_data_r <= '0;
      end
    end else begin
      case (lstate_r)
        ST_IDLE: begin
          lstate_r <= ST_CMD;
        end
        ST_CMD: begin
          cmd_r <= {cmd_r[CMD_W-2:0], din};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == LAST_CMD_BIT) begin
            bit_cnt_r <= 5'h00;
            lstate_r <= ST_DATA;
            in_data_r <= 1'b1;
          end
        end
        ST_DATA: begin
          in_sh_r <= {in_sh_r[WORD_W-2:0], din};
          bit_cnt_r <= bit_cnt_r + 5'h01;
          if (bit_cnt_r == LAST_WORD_BIT) begin
            bit_cnt_r <= 5'h00;
            lstate_r <= ST_CMD;
            in_data_r <= 1'b0;
            if (cmd_r[CMD_RW_POS] != CMD_READ_BIT) begin
              wr_sel_r <= cmd_sel(cmd_r);
              wr_data_r <= {in_sh_r[WORD_W-2:0], din};
              wr_tgl_r <= ~wr_tgl_r;
            end else if (cmd_sel(cmd_r) == DATA_REG_SEL) begin
              rd_tgl_r <= ~rd_tgl_r;
            end
          end
        end
        default: begin
          lstate_r <= ST_CMD;
        end
      endcase
    end
  end

  // Output shifting on falling sclk; ready shown between frames
  always_ff @(negedge sclk) begin
    if (link_rst) begin
      out_sh_r <= '0;
      out_bit_r <= 1'b1;
    end else if (lstate_r == ST_DATA && bit_cnt_r == 5'h00) begin
      out_sh_r <= {snap_r[cmd_sel(cmd_r)][WORD_W-2:0], 1'b0};
      out_bit_r <= snap_r[cmd_sel(cmd_r)][WORD_W-1];
    end else begin
      out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
      out_bit_r <= out_sh_r[WORD_W-1];
    end
  end

  // ==========================================================
  // System domain: pin synchronisers
  logic cs_s1_r;
  logic cs_s2_r;
  logic sync_s1_r;
  logic sync_s2_r;
  logic wr_s1_r;
  logic wr_s2_r;
  logic wr_s3_r;
  logic rd_s1_r;
  logic rd_s2_r;
  logic rd_s3_r;
  logic ob_s1_r;
  logic ob_s2_r;
  logic dp_s1_r;
  logic dp_s2_r;

  always_ff @(posedge mclk) begin
    cs_s1_r <= cs_n;
    cs_s2_r <= cs_s1_r;
    sync_s1_r <= sync_n;
    sync_s2_r <= sync_s1_r;
    wr_s1_r <= wr_tgl_r;
    wr_s2_r <= wr_s1_r;
    wr_s3_r <= wr_s2_r;
    rd_s1_r <= rd_tgl_r;
    rd_s2_r <= rd_s1_r;
    rd_s3_r <= rd_s2_r;
    ob_s1_r <= out_bit_r;
    ob_s2_r <= ob_s1_r;
    dp_s1_r <= in_data_r;
    dp_s2_r <= dp_s1_r;
  end

  // ==========================================================
  // Register writes through the two-entry buffer
  reg_write_t buf_in;
  reg_write_t buf_out;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic pend_r;
  reg_write_t pend_word_r;
  logic conv_done;

  assign buf_in = pend_word_r;
  assign buf_in_valid = pend_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      pend_word_r <= '0;
    end else if (wr_s2_r != wr_s3_r) begin
      pend_r <= 1'b1;
      pend_word_r <= '{sel: wr_sel_r, data: wr_data_r};
    end else if (buf_in_ready) begin
      pend_r <= 1'b0;
    end
  end

  word_buffer2 u_wbuf (
    .mclk(mclk),
    .resetn(resetn),
    .in_word(buf_in),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .out_word(buf_out),
    .out_valid(buf_out_valid),
    .out_ready(1'b1)
  );

  // Control registers; the data register is owned by conversion logic
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= RESET_VALUE_WORD;
      end
    end else begin
      if (buf_out_valid && buf_out.sel != DATA_REG_SEL) begin
        regs_r[buf_out.sel] <= buf_out.data;
      end
      if (conv_done) begin
        regs_r[DATA_REG_SEL] <= sample_in;
      end
    end
  end

  // ==========================================================
  // Conversion timing and ready
  logic [23:0] conv_cnt_r;
  logic rdy_n_r;
  logic sync_low;

  // Sync does not touch the link logic above
  assign sync_low = !sync_s2_r;
  assign conv_done = !sync_low && conv_cnt_r == CONV_PERIOD_DEF;

  always_ff @(posedge mclk) begin
    if (!resetn || sync_low) begin
      conv_cnt_r <= 24'h00_0000;
    end else if (conv_done) begin
      conv_cnt_r <= 24'h00_0000;
    end else begin
      conv_cnt_r <= conv_cnt_r + 24'h00_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      filter_reset <= 1'b1;
      modulator_reset <= 1'b1;
    end else begin
      filter_reset <= sync_low;
      modulator_reset <= sync_low;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rdy_n_r <= 1'b1;
    end else if (sync_low) begin
      rdy_n_r <= 1'b1;
    end else if (conv_done) begin
      rdy_n_r <= 1'b0;
    end else if (conv_cnt_r == CONV_PERIOD_DEF - READY_LEAD) begin
      rdy_n_r <= 1'b1;
    end else if (rd_s2_r != rd_s3_r) begin
      rdy_n_r <= 1'b1;
    end
  end

  // ==========================================================
  // Data-out pin: ready between frames, shifted data inside
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dout_rdy_o <= 1'b1;
      dout_rdy_oe <= 1'b0;
    end else begin
      dout_rdy_oe <= !cs_s2_r;
      if (cs_s2_r == 1'b0 && dp_s2_r) begin
        dout_rdy_o <= ob_s2_r;
      end else begin
        dout_rdy_o <= rdy_n_r;
      end
    end
  end

  // ==========================================================
  // Internal master clock divider
  logic [7:0] div_cnt_r;
  logic int_clk_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt_r <= 8'h00;
      int_clk_r <= 1'b0;
    end else if (div_cnt_r == INT_CLK_HALF_CNT - 8'h01) begin
      div_cnt_r <= 8'h00;
      int_clk_r <= ~int_clk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  // External clock drives the pin itself, so never drive it then
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      master_clock_pin_o <= 1'b0;
      master_clock_pin_oe <= 1'b0;
    end else begin
      master_clock_pin_o <= int_clk_r;
      master_clock_pin_oe <= clk_out_en && !ext_clk_sel;
    end
  end
endmodule

// ### dv/adc_port_checker_assertions.sv
/*
  Pin-level checker for the converter serial port, mclk domain.
  Assumes it is bound to adc_serial_port and sees only its ports.
*/
`timescale 1ns/1ps
module adc_port_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sync_n,
  input wire logic clk_out_en,
  input wire logic ext_clk_sel,
  input wire logic dout_rdy_o,
  input wire logic dout_rdy_oe,
  input wire logic master_clock_pin_o,
  input wire logic master_clock_pin_oe,
  input wire logic modulator_reset,
  input wire logic filter_reset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ====
  // Sequences
  sequence s_sync_low;
    !sync_n [*4];
  endsequence
  sequence s_cs_high;
    cs_n [*4];
  endsequence
  sequence s_half;
    $stable(master_clock_pin_o) [*4] ##1 $changed(master_clock_pin_o);
  endsequence
  // ====
  // Properties
  property p_sync_rst;
    s_sync_low |-> modulator_reset && filter_reset;
  endproperty
  a_sync_rst: assert property (p_sync_rst) else $error("filter reset missing");
  property p_sync_rel;
    sync_n [*6] |-> !modulator_reset && !filter_reset;
  endproperty
  a_sync_rel: assert property (p_sync_rel) else $error("filter reset stuck");
  property p_sync_rdy;
    (!sync_n && cs_n) [*4] |=> dout_rdy_o;
  endproperty
  a_sync_rdy: assert property (p_sync_rdy) else $error("ready not cleared");
  property p_oe_off;
    s_cs_high |-> !dout_rdy_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("line driven unselected");
  property p_oe_on;
    !cs_n [*4] |-> dout_rdy_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("line not driven");
  property p_clk_oe;
    (clk_out_en && !ext_clk_sel) [*3] |-> master_clock_pin_oe;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clock pin not driven");
  property p_clk_ext;
    ext_clk_sel [*3] |-> !master_clock_pin_oe;
  endproperty
  a_clk_ext: assert property (p_clk_ext) else $error("clock pin driven");
  property p_clk_half;
    master_clock_pin_oe && $changed(master_clock_pin_o) |=>
      s_half or (##[0:4] !master_clock_pin_oe);
  endproperty
  a_clk_half: assert property (p_clk_half) else $error("clock half period");
endmodule
bind adc_serial_port adc_port_checker i_chk (.mclk(mclk), .resetn(resetn), .cs_n(cs_n),
  .sync_n(sync_n), .clk_out_en(clk_out_en), .ext_clk_sel(ext_clk_sel),
  .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe),
  .master_clock_pin_o(master_clock_pin_o), .master_clock_pin_oe(master_clock_pin_oe),
  .modulator_reset(modulator_reset), .filter_reset(filter_reset));

// ### dv/host_model.sv
/*
  Host end of the serial link: select, serial clock and data in.
  Assumes the bench calls its tasks; sclk idles high between frames.
*/
`timescale 1ns/1ps
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout_rdy_o,
  input wire logic dout_rdy_oe
);
  logic pat = 1'b0;
  logic tie_low = 1'b0;
  wire logic line;
  // Released line shows a changing pattern
  assign line = dout_rdy_oe ? dout_rdy_o : pat;
  always #35 pat = ~pat;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // Select is seen after two sclk rises, so give them before data
  task select_link;
    idle_clk(2);
    cs_n = 1'b0;
    #200;
    idle_clk(2);
  endtask
  task set_tie(input logic t);
    tie_low = t;
    if (t) select_link();
    else cs_n = 1'b1;
  endtask
  task idle_clk(input int k);
    repeat (k) begin
      sclk = 1'b0;
      #100;
      sclk = 1'b1;
      #60;
    end
  endtask
  task frame(input logic [7:0] cmd, input logic [23:0] wd, input int nbits, input int gap,
             output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, wd};
    rd = 24'h00_0000;
    if (cs_n) select_link();
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'b0;
      din = sh[31-i];
      #100;
      if (i >= 8) rd[31-i] = line;
      sclk = 1'b1;
      #60;
      if (gap > 0 && i % 8 == 7) #(gap);
    end
    #100;
    if (!tie_low) cs_n = 1'b1;
    #300;
  endtask
endmodule

// ### dv/tb.sv
/*
  Self-checking bench for the converter serial port.
  Assumes host_model on the link and the bound pin checker.
*/
`timescale 1ns/1ps
module tb;
  import adc_port_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic sync_n = 1'b1;
  logic clk_out_en = 1'b1;
  logic ext_clk_sel = 1'b0;
  logic [23:0] sample_in = 24'h00_0000;
  logic sclk, cs_n, din, dout_rdy_o, dout_rdy_oe, mck_o, mck_oe, mod_rst, fil_rst, prev;
  logic [31:0] rng = 32'h0000_25a8;
  logic [23:0] rd, wd;
  logic [2:0] sel;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  always #10 mclk = ~mclk;
  adc_serial_port i_dut (.mclk(mclk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe), .sync_n(sync_n),
    .clk_out_en(clk_out_en), .ext_clk_sel(ext_clk_sel), .crystal_in_pin(1'b0),
    .master_clock_pin_o(mck_o), .master_clock_pin_oe(mck_oe), .sample_in(sample_in),
    .modulator_reset(mod_rst), .filter_reset(fil_rst));
  host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout_rdy_o(dout_rdy_o),
    .dout_rdy_oe(dout_rdy_oe));
  // ====
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  task chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task wait_line(input logic lvl);
    n = 0;
    while (i_host.line !== lvl && n < 12000) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 12000, "ready wait");
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      end_of_test();
    end
  end
  // ====
  // Main sequence
  initial begin
    i_host.idle_clk(3);
    repeat (4) @(negedge mclk);
    chk(dout_rdy_o === 1'b1 && dout_rdy_oe === 1'b0 && mod_rst === 1'b1 && mck_oe === 1'b0,
        "reset values");
    resetn = 1'b1;
    i_host.idle_clk(3);
    $display("test reset done");
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      sel = rng[2:0];
      wd = rng[31:8];
      if (sel == DATA_REG_SEL || sel == 3'h0) sel = 3'h5;
      if (k == 2) i_host.frame(8'h00, 24'h00_0000, 5, 0, rd);
      i_host.frame({2'b00, sel, 3'b000}, wd, 32, (k % 2) * 700, rd);
      i_host.frame({2'b01, sel, 3'b000}, 24'h00_0000, 32, 0, rd);
      chk(rd === wd, "register readback");
    end
    $display("test registers done");
    @(negedge mclk);
    sample_in = rng[23:0] ^ 24'h5a_5a5a;
    i_host.set_tie(1'b1);
    repeat (5) @(negedge mclk);
    wait_line(1'b1);
    wait_line(1'b0);
    i_host.frame(8'h58, 24'h00_0000, 32, 0, rd);
    chk(rd === sample_in, "result word");
    chk(i_host.line === 1'b1, "ready after read");
    wait_line(1'b0);
    wait_line(1'b1);
    wait_line(1'b0);
    chk(n >= 15 && n <= 17, "ready lead");
    $display("test ready done");
    sync_n = 1'b0;
    repeat (6) @(negedge mclk);
    chk(i_host.line === 1'b1 && mod_rst === 1'b1 && fil_rst === 1'b1, "sync");
    i_host.set_tie(1'b0);
    i_host.frame(8'h20, wd, 32, 0, rd);
    i_host.frame(8'h60, 24'h00_0000, 32, 0, rd);
    chk(rd === wd, "transfer under sync");
    @(negedge mclk);
    sync_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk(mod_rst === 1'b0 && fil_rst === 1'b0, "sync release");
    $display("test sync done");
    prev = mck_o;
    n = 0;
    repeat (100) begin
      @(negedge mclk);
      if (mck_o !== prev) n++;
      prev = mck_o;
    end
    chk(n == 20 && mck_oe === 1'b1, "clock out");
    ext_clk_sel = 1'b1;
    repeat (5) @(negedge mclk);
    chk(mck_oe === 1'b0, "external clock");
    ext_clk_sel = 1'b0;
    $display("test clock done");
    end_of_test();
  end
endmodule
